// *** bench/motion_ctrl_model.sv ***
// Behavioural motion controller driving the three command pins
`timescale 1ns/1ps
module motion_ctrl_model
(
	input wire logic clk,
	output logic step_pulse_input,
	output logic dir_input,
	output logic drive_enable_input
);
	// ------------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------------
	initial begin
		step_pulse_input = 1'b0;
		dir_input = 1'b0;
		drive_enable_input = 1'b1;
	end

	// Each level held at least six cycles, well above the two-clock minimum
	task put(input int idx, input logic v);
		@(posedge clk);
		case (idx)
			0: step_pulse_input <= v;
			1: dir_input <= v;
			default: drive_enable_input <= v;
		endcase
		repeat (5) @(posedge clk);
	endtask : put

	// Both pulse pins change in the same cycle
	task put_both(input logic v);
		@(posedge clk);
		step_pulse_input <= v;
		dir_input <= v;
		repeat (5) @(posedge clk);
	endtask : put_both
endmodule : motion_ctrl_model

// *** bench/step_command_input_decoder_tb.sv ***
// Self-checking bench for the step command decoder
`timescale 1ns/1ps
module step_command_input_decoder_tb;
	import step_decoder_pkg::*;
	logic clk, rst, cyc, stb, we, ack, step_pulse, step_dir, drive_enabled, pin_step, pin_dir, pin_ena;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	int failures = 0;
	int checks = 0;
	int cw_seen = 0;
	int ccw_seen = 0;
	logic [3:0] lanes = 4'hf;

	step_command_input_decoder dut (.clk(clk), .rst(rst), .step_pulse_input(pin_step), .dir_input(pin_dir),
		.drive_enable_input(pin_ena), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .step_pulse(step_pulse),
		.step_dir(step_dir), .drive_enabled(drive_enabled));
	motion_ctrl_model ctl (.clk(clk), .step_pulse_input(pin_step), .dir_input(pin_dir),
		.drive_enable_input(pin_ena));

	// ------------------------------------------------------------------------
	// Clock, step monitor, watchdog
	// ------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		if (step_pulse === 1'b1) begin
			if (step_dir === 1'b1) ccw_seen++;
			else cw_seen++;
		end
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		complete_run();
	end

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task wb_rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= lanes;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (n >= 100) check("wb ack", 32'h0, 32'h1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb_rw

	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		wb_rw(1'b0, a, 32'h0);
		check(nm, rd, exp);
	endtask : rd_chk

	task complete_run;
		if (failures == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		rd_chk("ctrl", 8'h00, 32'h0000000c);
		rd_chk("status", 8'h04, 32'h00000011);
		rd_chk("unmapped", 8'h10, 32'h0);
		ctl.put(0, 1'b1);
		check("rise step", cw_seen, 1);
		ctl.put(0, 1'b0);
		check("fall ignored", cw_seen, 1);
		ctl.put(1, 1'b1);
		ctl.put(0, 1'b1);
		ctl.put(0, 1'b0);
		check("ccw step", ccw_seen, 1);
		ctl.put(1, 1'b0);
		rd_chk("position", 8'h08, 32'h0);
		rd_chk("count", 8'h0c, 32'h2);
		// Inverted edge in sinking wiring
		wb_rw(1'b1, 8'h00, 32'h0000000e);
		ctl.put(0, 1'b1);
		check("inv rise", cw_seen, 1);
		ctl.put(0, 1'b0);
		check("inv fall", cw_seen, 2);
		rd_chk("falling", 8'h04, 32'h00000051);
		// Sourcing wiring, then enable polarity in differential and sinking wiring
		wb_rw(1'b1, 8'h00, 32'h0000001c);
		ctl.put(0, 1'b1);
		check("src rise", cw_seen, 2);
		ctl.put(0, 1'b0);
		check("src fall", cw_seen, 3);
		check("src ena hi", drive_enabled, 32'h0);
		ctl.put(2, 1'b0);
		check("src ena lo", drive_enabled, 32'h1);
		wb_rw(1'b1, 8'h00, 32'h0000002c);
		repeat (4) @(posedge clk);
		check("diff ena lo", drive_enabled, 32'h1);
		ctl.put(2, 1'b1);
		check("diff ena hi", drive_enabled, 32'h0);
		wb_rw(1'b1, 8'h00, 32'h0000000c);
		repeat (4) @(posedge clk);
		check("sink ena hi", drive_enabled, 32'h1);
		ctl.put(2, 1'b0);
		check("sink ena lo", drive_enabled, 32'h0);
		ctl.put(2, 1'b1);
		// Dual pulse, active high
		wb_rw(1'b1, 8'h00, 32'h0000000d);
		ctl.put(0, 1'b1);
		check("dual cw", cw_seen, 4);
		ctl.put(0, 1'b0);
		ctl.put(1, 1'b1);
		check("dual ccw", ccw_seen, 2);
		ctl.put(1, 1'b0);
		check("dual ccw fall", ccw_seen, 2);
		ctl.put(0, 1'b1);
		ctl.put(1, 1'b1);
		// Dual pulse, active low
		wb_rw(1'b1, 8'h00, 32'h00000001);
		rd_chk("ctrl rb", 8'h00, 32'h00000001);
		ctl.put(0, 1'b0);
		check("low cw", cw_seen, 6);
		ctl.put(0, 1'b1);
		check("low cw rise", cw_seen, 6);
		ctl.put(1, 1'b0);
		check("low ccw", ccw_seen, 4);
		rd_chk("position end", 8'h08, 32'h00000002);
		rd_chk("count end", 8'h0c, 32'h0000000a);
		// Dual pulse collision and sticky flag
		wb_rw(1'b1, 8'h00, 32'h0000000d);
		ctl.put(0, 1'b0);
		ctl.put_both(1'b1);
		check("collide cw", cw_seen, 6);
		check("collide ccw", ccw_seen, 4);
		rd_chk("collision", 8'h04, 32'h0000003f);
		wb_rw(1'b1, 8'h04, 32'h00000020);
		rd_chk("collision clr", 8'h04, 32'h0000001f);
		// Byte lanes, counter clear, unmapped write
		lanes = 4'h3;
		wb_rw(1'b1, 8'h08, 32'h12345678);
		lanes = 4'hf;
		rd_chk("position lanes", 8'h08, 32'h00005678);
		wb_rw(1'b1, 8'h0c, 32'h00000000);
		rd_chk("count clr", 8'h0c, 32'h0);
		wb_rw(1'b1, 8'h10, 32'hffffffff);
		rd_chk("ctrl kept", 8'h00, 32'h0000000d);
		// Sourcing wiring with inverted edge steps on rising
		wb_rw(1'b1, 8'h00, 32'h0000001e);
		rd_chk("src inv status", 8'h04, 32'h0000001e);
		ctl.put(0, 1'b0);
		check("src inv fall", ccw_seen, 4);
		ctl.put(0, 1'b1);
		check("src inv rise", ccw_seen, 5);
		rd_chk("position step", 8'h08, 32'h00005677);
		rd_chk("count step", 8'h0c, 32'h00000001);
		// Reset in mid-run with the step pin held high
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		check("reset no step", cw_seen + ccw_seen, 11);
		rd_chk("ctrl reset", 8'h00, 32'h0000000c);
		rd_chk("count reset", 8'h0c, 32'h0);
		complete_run();
	end
endmodule : step_command_input_decoder_tb

// *** rtl/input_sync.sv ***
// Two-stage synchroniser with one history stage for edge detection
`timescale 1ns/1ps
module input_sync
	import step_decoder_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic lvl,
	output logic prev
);

	sync_state_t st_reg;
	sync_state_t st_next;

	// ------------------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.meta = pin;
		st_next.lvl = st_reg.meta;
		st_next.prev = st_reg.lvl;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// History loaded with the pin, so a level held through reset is no edge
			st_reg.meta <= pin;
			st_reg.lvl <= pin;
			st_reg.prev <= pin;
		end else begin
			st_reg <= st_next;
		end
	end

	assign lvl = st_reg.lvl;
	assign prev = st_reg.prev;

endmodule : input_sync

// *** rtl/step_command_input_decoder.sv ***
// Step command input decoder with classic Wishbone register slave
// Contract
// - Step/dir mode: each selected step edge steps
// - Step/dir mode: direction level picks rotation
// - Dual mode: step input pulses mean clockwise
// - Dual mode: direction input pulses mean counterclockwise
// - Dual mode: pulse active level configurable
// - Sinking wiring: enable high enables drive
// - Sourcing/differential wiring: enable low enables drive
// - Default: step/dir mode, rising edge
// - Sourcing wiring default edge is falling
// - Exactly three command inputs: step, direction, enable
`timescale 1ns/1ps
`include "step_decoder_params.svh"
module step_command_input_decoder
	import step_decoder_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic step_pulse_input,
	input wire logic dir_input,
	input wire logic drive_enable_input,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic step_pulse,
	output logic step_dir,
	output logic drive_enabled
);

	dec_state_t st_reg;
	dec_state_t st_next;

	logic step_lvl;
	logic step_prev;
	logic dir_lvl;
	logic dir_prev;
	logic ena_lvl;
	logic step_rise;
	logic step_fall;
	logic dir_rise;
	logic dir_fall;
	logic falling_sel;
	logic sd_hit;
	logic cw_hit;
	logic ccw_hit;
	logic bus_req;
	logic bus_wr;
	logic [31:0] status_word;
	logic [31:0] ctrl_word;

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	input_sync u_sync_step (
		.clk(clk),
		.rst(rst),
		.pin(step_pulse_input),
		.lvl(step_lvl),
		.prev(step_prev)
	);

	input_sync u_sync_dir (
		.clk(clk),
		.rst(rst),
		.pin(dir_input),
		.lvl(dir_lvl),
		.prev(dir_prev)
	);

	input_sync u_sync_ena (
		.clk(clk),
		.rst(rst),
		.pin(drive_enable_input),
		.lvl(ena_lvl),
		.prev()
	);

	// ------------------------------------------------------------------------
	// Edge qualification
	// ------------------------------------------------------------------------
	assign step_rise = step_lvl & ~step_prev;
	assign step_fall = ~step_lvl & step_prev;
	assign dir_rise = dir_lvl & ~dir_prev;
	assign dir_fall = ~dir_lvl & dir_prev;

	// Sourcing wiring flips the default edge
	assign falling_sel = (st_reg.wiring == WIRING_SOURCING) ^ st_reg.edge_inv;
	assign sd_hit = (st_reg.mode == MODE_STEP_DIR) & (falling_sel ? step_fall : step_rise);
	assign cw_hit = (st_reg.mode == MODE_DUAL_PULSE) & (st_reg.cw_high ? step_rise : step_fall);
	assign ccw_hit = (st_reg.mode == MODE_DUAL_PULSE) & (st_reg.ccw_high ? dir_rise : dir_fall);

	// ------------------------------------------------------------------------
	// Bus decode helpers
	// ------------------------------------------------------------------------
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_wr = bus_req & wb_we_i & st_reg.ack;

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[`CTRL_MODE_BIT] = st_reg.mode;
		ctrl_word[`CTRL_EDGE_INV_BIT] = st_reg.edge_inv;
		ctrl_word[`CTRL_CW_HIGH_BIT] = st_reg.cw_high;
		ctrl_word[`CTRL_CCW_HIGH_BIT] = st_reg.ccw_high;
		ctrl_word[`CTRL_WIRING_MSB:`CTRL_WIRING_LSB] = st_reg.wiring;
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`STAT_DRIVE_EN_BIT] = st_reg.drive_en;
		status_word[`STAT_DIR_BIT] = st_reg.step_dir;
		status_word[`STAT_STEP_LVL_BIT] = step_lvl;
		status_word[`STAT_DIR_LVL_BIT] = dir_lvl;
		status_word[`STAT_ENA_LVL_BIT] = ena_lvl;
		status_word[`STAT_COLLISION_BIT] = st_reg.collision;
		status_word[`STAT_FALLING_BIT] = falling_sel;
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.ack = bus_req & ~st_reg.ack;
		st_next.step_pulse = 1'b0;

		// Read data captured with the request, held through ack
		if (bus_req & ~st_reg.ack & ~wb_we_i) begin
			if (wb_adr_i == `CTRL_OFFSET) begin
				st_next.rdata = ctrl_word;
			end else if (wb_adr_i == `STATUS_OFFSET) begin
				st_next.rdata = status_word;
			end else if (wb_adr_i == `POSITION_OFFSET) begin
				st_next.rdata = st_reg.position;
			end else if (wb_adr_i == `STEP_COUNT_OFFSET) begin
				st_next.rdata = st_reg.step_count;
			end else begin
				st_next.rdata = 32'h0000_0000;
			end
		end

		// Step generation
		if (sd_hit) begin
			st_next.step_pulse = 1'b1;
			st_next.step_dir = dir_lvl;
		end else if (cw_hit & ~ccw_hit) begin
			st_next.step_pulse = 1'b1;
			st_next.step_dir = 1'b0;
		end else if (ccw_hit & ~cw_hit) begin
			st_next.step_pulse = 1'b1;
			st_next.step_dir = 1'b1;
		end

		if (st_next.step_pulse) begin
			st_next.position = st_next.step_dir ? st_reg.position - 32'h0000_0001
				: st_reg.position + 32'h0000_0001;
			st_next.step_count = st_reg.step_count + 32'h0000_0001;
		end

		// Drive enable polarity follows wiring
		if (st_reg.wiring == WIRING_SINKING) begin
			st_next.drive_en = ena_lvl;
		end else begin
			st_next.drive_en = ~ena_lvl;
		end

		// Register writes, committed on the ack edge
		if (bus_wr) begin
			if (wb_adr_i == `CTRL_OFFSET) begin
				if (wb_sel_i[0]) begin
					st_next.mode = cmd_mode_t'(wb_dat_i[`CTRL_MODE_BIT]);
					st_next.edge_inv = wb_dat_i[`CTRL_EDGE_INV_BIT];
					st_next.cw_high = wb_dat_i[`CTRL_CW_HIGH_BIT];
					st_next.ccw_high = wb_dat_i[`CTRL_CCW_HIGH_BIT];
					st_next.wiring = wiring_t'(wb_dat_i[`CTRL_WIRING_MSB:`CTRL_WIRING_LSB]);
				end
			end else if (wb_adr_i == `STATUS_OFFSET) begin
				if (wb_sel_i[0] & wb_dat_i[`STAT_COLLISION_BIT]) begin
					st_next.collision = 1'b0;
				end
			end else if (wb_adr_i == `POSITION_OFFSET) begin
				for (int i = 0; i < 4; i++) begin
					if (wb_sel_i[i]) begin
						st_next.position[i*8 +: 8] = wb_dat_i[i*8 +: 8];
					end
				end
			end else if (wb_adr_i == `STEP_COUNT_OFFSET) begin
				st_next.step_count = `STEP_COUNT_RESET;
			end
		end

		// Simultaneous opposite pulses cancel; flag set beats clear
		if (cw_hit & ccw_hit) begin
			st_next.collision = 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.mode <= MODE_STEP_DIR;
			st_reg.edge_inv <= `CTRL_EDGE_INV_RESET;
			st_reg.cw_high <= `CTRL_CW_HIGH_RESET;
			st_reg.ccw_high <= `CTRL_CCW_HIGH_RESET;
			st_reg.wiring <= WIRING_SINKING;
			st_reg.position <= `POSITION_RESET;
			st_reg.step_count <= `STEP_COUNT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;
	assign step_pulse = st_reg.step_pulse;
	assign step_dir = st_reg.step_dir;
	assign drive_enabled = st_reg.drive_en;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	property p_sd_step;
		@(posedge clk) disable iff (rst)
		(st_reg.mode == MODE_STEP_DIR && !falling_sel && step_rise) |=> step_pulse;
	endproperty
	a_sd_step: assert property (p_sd_step) else $error("step edge did not produce a step");

	property p_sd_dir;
		@(posedge clk) disable iff (rst)
		sd_hit |=> (step_dir == $past(dir_lvl));
	endproperty
	a_sd_dir: assert property (p_sd_dir) else $error("direction does not follow dir level");

	property p_cw;
		@(posedge clk) disable iff (rst)
		(st_reg.mode == MODE_DUAL_PULSE && st_reg.cw_high && step_rise && !ccw_hit) |=> (step_pulse && !step_dir);
	endproperty
	a_cw: assert property (p_cw) else $error("clockwise pulse not decoded");

	property p_ccw;
		@(posedge clk) disable iff (rst)
		(st_reg.mode == MODE_DUAL_PULSE && st_reg.ccw_high && dir_rise && !cw_hit) |=> (step_pulse && step_dir);
	endproperty
	a_ccw: assert property (p_ccw) else $error("counterclockwise pulse not decoded");

	property p_low_level;
		@(posedge clk) disable iff (rst)
		(st_reg.mode == MODE_DUAL_PULSE && !st_reg.cw_high && step_fall && !ccw_hit) ##1 1'b1
		|-> (step_pulse && !step_dir);
	endproperty
	a_low_level: assert property (p_low_level) else $error("low active clockwise pulse missed");

	property p_ena_sink;
		@(posedge clk) disable iff (rst)
		(st_reg.wiring == WIRING_SINKING) |=> (drive_enabled == $past(ena_lvl));
	endproperty
	a_ena_sink: assert property (p_ena_sink) else $error("sinking enable polarity wrong");

	property p_ena_src;
		@(posedge clk) disable iff (rst)
		(st_reg.wiring != WIRING_SINKING) |=> (drive_enabled == !$past(ena_lvl));
	endproperty
	a_ena_src: assert property (p_ena_src) else $error("sourcing enable polarity wrong");

	property p_defaults;
		@(posedge clk)
		$fell(rst) |-> (st_reg.mode == MODE_STEP_DIR && !falling_sel);
	endproperty
	a_defaults: assert property (p_defaults) else $error("reset default not step/dir rising");

	property p_src_fall;
		@(posedge clk) disable iff (rst)
		(st_reg.mode == MODE_STEP_DIR && st_reg.wiring == WIRING_SOURCING && !st_reg.edge_inv && step_fall)
		|=> step_pulse;
	endproperty
	a_src_fall: assert property (p_src_fall) else $error("sourcing falling edge not stepped");

	property p_one_step;
		@(posedge clk) disable iff (rst)
		step_pulse |-> ($past(step_lvl) != $past(step_prev) || $past(dir_lvl) != $past(dir_prev))
			&& ($past(st_reg.mode) == MODE_DUAL_PULSE || !$past(step_pulse));
	endproperty
	a_one_step: assert property (p_one_step) else $error("step without one synchronised edge");

	property p_bus_ack;
		@(posedge clk) disable iff (rst)
		(bus_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("ack not a single cycle after request");

endmodule : step_command_input_decoder

// *** rtl/step_decoder_params.svh ***
// Register map, field positions and reset values of the step command decoder
`ifndef STEP_DECODER_PARAMS_SVH
`define STEP_DECODER_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define POSITION_OFFSET 8'h08
`define STEP_COUNT_OFFSET 8'h0c

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_MODE_BIT 0
`define CTRL_EDGE_INV_BIT 1
`define CTRL_CW_HIGH_BIT 2
`define CTRL_CCW_HIGH_BIT 3
`define CTRL_WIRING_LSB 4
`define CTRL_WIRING_MSB 5

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define STAT_DRIVE_EN_BIT 0
`define STAT_DIR_BIT 1
`define STAT_STEP_LVL_BIT 2
`define STAT_DIR_LVL_BIT 3
`define STAT_ENA_LVL_BIT 4
`define STAT_COLLISION_BIT 5
`define STAT_FALLING_BIT 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CTRL_EDGE_INV_RESET 1'h0
`define CTRL_CW_HIGH_RESET 1'h1
`define CTRL_CCW_HIGH_RESET 1'h1
`define POSITION_RESET 32'h0000_0000
`define STEP_COUNT_RESET 32'h0000_0000

`endif

// *** rtl/step_decoder_pkg.sv ***
// Types shared by the step command decoder modules
package step_decoder_pkg;

	// ------------------------------------------------------------------------
	// Modes and wiring
	// ------------------------------------------------------------------------
	typedef enum logic [0:0] {MODE_STEP_DIR, MODE_DUAL_PULSE} cmd_mode_t;
	typedef enum logic [1:0] {WIRING_SINKING, WIRING_SOURCING, WIRING_DIFFERENTIAL, WIRING_RESERVED} wiring_t;

	// ------------------------------------------------------------------------
	// State records
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic meta;
		logic lvl;
		logic prev;
	} sync_state_t;

	typedef struct packed {
		cmd_mode_t mode;
		logic edge_inv;
		logic cw_high;
		logic ccw_high;
		wiring_t wiring;
		logic [31:0] position;
		logic [31:0] step_count;
		logic collision;
		logic ack;
		logic [31:0] rdata;
		logic step_pulse;
		logic step_dir;
		logic drive_en;
	} dec_state_t;

endpackage : step_decoder_pkg
